/* File: hw/shift_compare_regs.svh */
// Constants for the shift and compare datapath: widths, opcodes,
// compare selectors and reset values.
// Assumes a 30-bit word with the sign in the top bit.
`ifndef SHIFT_COMPARE_REGS_SVH
`define SHIFT_COMPARE_REGS_SVH

// Word and field widths
`define WORD_W 30
`define PAIR_W 60
`define COUNT_W 6
`define OPCODE_W 6
`define SEL_W 3

// Opcodes handled by this datapath
`define OP_SHR_EXT 6'h01
`define OP_SHR_SUM 6'h02
`define OP_SHR_PAIR 6'h03
`define OP_COMPARE 6'h04
`define OP_ROL_EXT 6'h05
`define OP_ROL_SUM 6'h06

// Skip selector codes
`define SEL_NEVER 3'h0
`define SEL_ALWAYS 3'h1
`define SEL_LE_EXT 3'h2
`define SEL_GT_EXT 3'h3
`define SEL_IN_RANGE 3'h4
`define SEL_OUT_RANGE 3'h5
`define SEL_LE_SUM 3'h6
`define SEL_GT_SUM 3'h7

// Rotation folding points and reset values
`define ROT_WRAP1 6'h1e
`define ROT_WRAP2 6'h3c
`define WORD_RST 30'h0000_0000

`endif

/* File: hw/shift_compare_pkg.sv */
// Types shared by the shift and compare datapath files.
// Assumes the constants header is on the include path.
`include "shift_compare_regs.svh"

package shift_compare_pkg;

	typedef logic [`WORD_W-1:0] word_t;
	typedef logic [`PAIR_W-1:0] pair_t;
	typedef logic [`COUNT_W-1:0] count_t;
	typedef logic [`OPCODE_W-1:0] opcode_t;
	typedef logic [`SEL_W-1:0] sel_t;

	// Whole state of the datapath top
	typedef struct packed {
		word_t sum;
		word_t ext;
		logic skip;
		logic done;
	} core_state_t;

	// Results of the shift unit; it is purely combinational and holds no state
	typedef struct packed {
		word_t sum;
		word_t ext;
	} unit_result_t;

endpackage

/* File: hw/shift_if.sv */
// Interface between the datapath top and its shift unit.
// Assumes both ends share one clock; the unit answers in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "shift_compare_regs.svh"

interface shift_if;
	import shift_compare_pkg::*;

	opcode_t op;
	count_t count;
	word_t sum;
	word_t ext;
	word_t res_sum;
	word_t res_ext;

	// Top side: drives operands, reads results
	modport core (
		output op,
		output count,
		output sum,
		output ext,
		input res_sum,
		input res_ext
	);

	// Unit side: reads operands, drives results
	modport unit (
		input op,
		input count,
		input sum,
		input ext,
		output res_sum,
		output res_ext
	);

endinterface

`default_nettype wire

/* File: hw/shift_unit.sv */
// Combinational shifter for the sum, extension and paired registers.
// Assumes the count is already cut to six bits by the caller.
`timescale 1ns/10ps
`default_nettype none
`include "shift_compare_regs.svh"

module shift_unit
	import shift_compare_pkg::*;
(
	shift_if.unit sif
);

	unit_result_t res_d;

	// -------------------------------------------------------------
	// Shift network
	// -------------------------------------------------------------

	// Counts above the word length fold back; 30 places of rotation
	// return the word to itself, so folding keeps the result exact
	function automatic count_t fold_count(input count_t c);
		count_t r;
		r = c;
		if (c >= `ROT_WRAP2) begin
			r = c - `ROT_WRAP2;
		end else if (c >= `ROT_WRAP1) begin
			r = c - `ROT_WRAP1;
		end
		return r;
	endfunction

	// Left rotation through a doubled word
	function automatic word_t rotl(input word_t w, input count_t c);
		pair_t dbl;
		dbl = {w, w} << fold_count(c);
		return dbl[`PAIR_W-1:`WORD_W];
	endfunction

	always_comb begin
		logic signed [`WORD_W-1:0] s_sum;
		logic signed [`WORD_W-1:0] s_ext;
		logic signed [`PAIR_W-1:0] s_pair;
		s_sum = sif.sum;
		s_ext = sif.ext;
		s_pair = {sif.sum, sif.ext};
		res_d.sum = sif.sum;
		res_d.ext = sif.ext;
		unique case (sif.op)
			`OP_SHR_EXT: begin
				res_d.ext = s_ext >>> sif.count;
			end
			`OP_SHR_SUM: begin
				res_d.sum = s_sum >>> sif.count;
			end
			`OP_SHR_PAIR: begin
				// Sign of the sum half fills the top of the pair
				s_pair = s_pair >>> sif.count;
				res_d.sum = s_pair[`PAIR_W-1:`WORD_W];
				res_d.ext = s_pair[`WORD_W-1:0];
			end
			`OP_ROL_EXT: begin
				res_d.ext = rotl(sif.ext, sif.count);
			end
			`OP_ROL_SUM: begin
				res_d.sum = rotl(sif.sum, sif.count);
			end
			default: begin
				res_d.sum = sif.sum;
				res_d.ext = sif.ext;
			end
		endcase
	end

	assign sif.res_sum = res_d.sum;
	assign sif.res_ext = res_d.ext;

endmodule

`default_nettype wire

/* File: hw/shift_compare_datapath.sv */
// Shift and compare part of the arithmetic datapath: sum and extension
// registers, their right and circular shifts, and the signed compare
// that produces the skip decision.
// Assumes the sequencer presents one operation per cycle at most and
// acts on the skip flag in the cycle that the done pulse marks.
`timescale 1ns/10ps
`default_nettype none
`include "shift_compare_regs.svh"

// Functional notes
// - Opcode 01 shifts extension right, sign fill.
// - Opcode 02 shifts sum right, sign fill.
// - Shift count is low six operand bits.
// - Opcode 03 shifts sum:extension pair right.
// - Pair shift fills with sum sign.
// - Opcode 05 rotates extension left.
// - Opcode 06 rotates sum left.
// - Opcode 04 compares signed, registers unchanged.
// - Selector 0 never skips, 1 always.
// - Selector 2 operand<=ext, 3 operand>ext.
// - Selector 4 ext>=operand and operand>sum.
// - Selector 5 operand>ext or operand<=sum.
// - Selector 6 operand<=sum, 7 operand>sum.
module shift_compare_datapath
	import shift_compare_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic op_valid,
	input wire opcode_t opcode,
	input wire word_t operand,
	input wire sel_t skip_sel,
	input wire logic load_sum,
	input wire logic load_ext,
	input wire word_t load_data,
	output logic op_accept,
	output logic op_done,
	output logic skip,
	output word_t sum_out,
	output word_t ext_out
);

	core_state_t state_q;
	core_state_t state_d;
	shift_if sif ();

	logic op_legal;
	logic is_compare;
	logic signed [`WORD_W-1:0] s_opnd;
	logic signed [`WORD_W-1:0] s_sum;
	logic signed [`WORD_W-1:0] s_ext;
	logic opnd_le_ext;
	logic opnd_gt_ext;
	logic opnd_le_sum;
	logic opnd_gt_sum;
	logic skip_cmp;

	// -------------------------------------------------------------
	// Operation decode
	// -------------------------------------------------------------

	// Only the six opcodes of this datapath are taken; anything else is
	// left to other units and neither changes state nor pulses done
	always_comb begin
		op_legal = 1'b0;
		unique case (opcode)
			`OP_SHR_EXT,
			`OP_SHR_SUM,
			`OP_SHR_PAIR,
			`OP_COMPARE,
			`OP_ROL_EXT,
			`OP_ROL_SUM: begin
				op_legal = 1'b1;
			end
			default: begin
				op_legal = 1'b0;
			end
		endcase
	end

	assign is_compare = (opcode == `OP_COMPARE);
	assign op_accept = op_valid & op_legal;

	// -------------------------------------------------------------
	// Shift unit hookup
	// -------------------------------------------------------------

	// Upper 24 operand bits never reach the shifter
	assign sif.op = opcode;
	assign sif.count = operand[`COUNT_W-1:0];
	assign sif.sum = state_q.sum;
	assign sif.ext = state_q.ext;

	shift_unit shift_unit_i (
		.sif(sif)
	);

	// -------------------------------------------------------------
	// Signed compare
	// -------------------------------------------------------------

	// Two's complement view of all three words
	assign s_opnd = operand;
	assign s_sum = state_q.sum;
	assign s_ext = state_q.ext;

	assign opnd_le_ext = (s_opnd <= s_ext);
	assign opnd_gt_ext = (s_opnd > s_ext);
	assign opnd_le_sum = (s_opnd <= s_sum);
	assign opnd_gt_sum = (s_opnd > s_sum);

	// Selector picks one relation; all eight codes are legal
	always_comb begin
		skip_cmp = 1'b0;
		unique case (skip_sel)
			`SEL_NEVER: begin
				skip_cmp = 1'b0;
			end
			`SEL_ALWAYS: begin
				skip_cmp = 1'b1;
			end
			`SEL_LE_EXT: begin
				skip_cmp = opnd_le_ext;
			end
			`SEL_GT_EXT: begin
				skip_cmp = opnd_gt_ext;
			end
			`SEL_IN_RANGE: begin
				skip_cmp = opnd_le_ext & opnd_gt_sum;
			end
			`SEL_OUT_RANGE: begin
				skip_cmp = opnd_gt_ext | opnd_le_sum;
			end
			`SEL_LE_SUM: begin
				skip_cmp = opnd_le_sum;
			end
			`SEL_GT_SUM: begin
				skip_cmp = opnd_gt_sum;
			end
		endcase
	end

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------

	// An accepted operation wins over a load in the same cycle, so a
	// shift never mixes with an entered value
	always_comb begin
		state_d = state_q;
		state_d.done = 1'b0;
		state_d.skip = 1'b0;
		if (op_accept) begin
			state_d.done = 1'b1;
			if (is_compare) begin
				state_d.skip = skip_cmp;
				state_d.sum = state_q.sum;
				state_d.ext = state_q.ext;
			end else begin
				state_d.sum = sif.res_sum;
				state_d.ext = sif.res_ext;
			end
		end else begin
			if (load_sum) begin
				state_d.sum = load_data;
			end
			if (load_ext) begin
				state_d.ext = load_data;
			end
		end
	end

	// -------------------------------------------------------------
	// State register
	// -------------------------------------------------------------

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q.sum <= `WORD_RST;
			state_q.ext <= `WORD_RST;
			state_q.skip <= 1'b0;
			state_q.done <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs straight from flip-flops
	assign op_done = state_q.done;
	assign skip = state_q.skip;
	assign sum_out = state_q.sum;
	assign ext_out = state_q.ext;

endmodule

`default_nettype wire

/* File: tb/sequencer_model.sv */
// Sequencer stand-in: counts the instructions that the skip flag passes over.
// Assumes the datapath marks each result with a one-cycle done pulse.
`timescale 1ns/10ps
`default_nettype none

module sequencer_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic op_done,
	input wire logic skip,
	output logic [7:0] skipped_q
);
	// The flag only counts while done marks it as valid
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			skipped_q <= 8'h00;
		end else if (op_done && skip) begin
			skipped_q <= skipped_q + 8'h01;
		end
	end
endmodule

`default_nettype wire

/* File: tb/shift_compare_datapath_properties.sv */
// Port-level assertions for the shift and compare datapath.
// Assumes one clock and the constants header on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "shift_compare_regs.svh"

module shift_compare_datapath_properties
	import shift_compare_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire opcode_t opcode,
	input wire word_t operand,
	input wire sel_t skip_sel,
	input wire logic op_accept,
	input wire logic op_done,
	input wire logic skip,
	input wire word_t sum_out,
	input wire word_t ext_out
);
	// Values as they stood before the edge that took the operation
	word_t sum_q;
	word_t ext_q;
	word_t opnd_q;
	sel_t sel_q;
	always_ff @(posedge clk) begin
		sum_q <= sum_out;
		ext_q <= ext_out;
		opnd_q <= operand;
		sel_q <= skip_sel;
	end

	// Signed assignment first, so the shift fills with the sign
	function automatic pair_t sra(pair_t x, logic [5:0] n);
		logic signed [59:0] v;
		v = x;
		return v >>> n;
	endfunction

	function automatic logic want(sel_t l, word_t y, word_t a, word_t q);
		logic signed [29:0] sy, sa, sq;
		sy = y;
		sa = a;
		sq = q;
		case (l)
			3'h0: return 1'b0;
			3'h1: return 1'b1;
			3'h2: return sy <= sq;
			3'h3: return sy > sq;
			3'h4: return sq >= sy && sy > sa;
			3'h5: return sy > sq || sy <= sa;
			3'h6: return sy <= sa;
			default: return sy > sa;
		endcase
	endfunction

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_op(logic [5:0] c);
		op_accept && opcode == c;
	endsequence

	property p_done; op_accept |=> op_done; endproperty
	a_done: assert property (p_done) else $error("done missing");
	property p_idle; !op_accept |=> !op_done && !skip; endproperty
	a_idle: assert property (p_idle) else $error("stray done or skip");
	property p_shr_ext;
		s_op(`OP_SHR_EXT) |=> ext_out == sra({ext_q, 30'h0000_0000}, opnd_q[5:0]) >> 30;
	endproperty
	a_shr_ext: assert property (p_shr_ext) else $error("ext shift wrong");
	property p_shr_sum;
		s_op(`OP_SHR_SUM) |=> sum_out == sra({sum_q, 30'h0000_0000}, opnd_q[5:0]) >> 30;
	endproperty
	a_shr_sum: assert property (p_shr_sum) else $error("sum shift wrong");
	property p_pair;
		s_op(`OP_SHR_PAIR) |=> {sum_out, ext_out} == sra({sum_q, ext_q}, opnd_q[5:0]);
	endproperty
	a_pair: assert property (p_pair) else $error("pair shift wrong");
	property p_keep; s_op(`OP_COMPARE) |=> $stable(sum_out) && $stable(ext_out); endproperty
	a_keep: assert property (p_keep) else $error("compare moved a register");
	property p_skip; s_op(`OP_COMPARE) |=> skip == want(sel_q, opnd_q, sum_q, ext_q); endproperty
	a_skip: assert property (p_skip) else $error("skip decision wrong");
	property p_shift_noskip; s_op(`OP_ROL_SUM) or s_op(`OP_ROL_EXT) |=> op_done && !skip; endproperty
	a_shift_noskip: assert property (p_shift_noskip) else $error("rotate gave skip");
endmodule

bind shift_compare_datapath shift_compare_datapath_properties shift_compare_datapath_properties_i (
	.clk, .nrst, .opcode, .operand, .skip_sel, .op_accept, .op_done, .skip, .sum_out, .ext_out);

`default_nettype wire

/* File: tb/shift_compare_datapath_tb_top.sv */
// Directed bench for the shift and compare datapath.
// Assumes the design, its checker and the sequencer model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "shift_compare_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t got %h want %h", $time, (a), (b)); end end

module shift_compare_datapath_tb_top;
	import shift_compare_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, load_sum = 1'b0, load_ext = 1'b0;
	opcode_t opcode = 6'h00;
	word_t operand = 30'h0000_0000, load_data = 30'h0000_0000, sum_out, ext_out;
	sel_t skip_sel = 3'h0;
	logic op_accept, op_done, skip;
	logic [7:0] skipped_q;
	int err_count = 0, tests_run = 0, nskip = 0;

	always #5 clk = ~clk;

	shift_compare_datapath shift_compare_datapath_i (.clk, .nrst, .op_valid, .opcode, .operand,
		.skip_sel, .load_sum, .load_ext, .load_data, .op_accept, .op_done, .skip, .sum_out, .ext_out);
	sequencer_model sequencer_model_i (.clk, .nrst, .op_done, .skip, .skipped_q);

	// Loads go one per cycle so each register gets its own value
	task automatic ld(word_t s, word_t e);
		@(posedge clk);
		load_sum <= 1'b1;
		load_data <= s;
		@(posedge clk);
		load_sum <= 1'b0;
		load_ext <= 1'b1;
		load_data <= e;
		@(posedge clk);
		load_ext <= 1'b0;
		#1;
	endtask

	// One request, held for the single edge that takes it
	task automatic op(opcode_t c, word_t y, sel_t l);
		@(posedge clk);
		op_valid <= 1'b1;
		opcode <= c;
		operand <= y;
		skip_sel <= l;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic t_shift();
		word_t e;
		logic [59:0] p;
		ld(30'h2345_6789, 30'h2000_0005);
		op(`OP_SHR_EXT, 30'h3fff_ffc2, 3'h0);
		e = $signed(30'h2000_0005) >>> 2;
		`CHK(ext_out, e)
		`CHK(op_done, 1'b1)
		op(`OP_SHR_SUM, 30'h0000_0023, 3'h0);
		`CHK(sum_out, 30'h3fff_ffff)
		ld(30'h2345_6789, 30'h0000_0005);
		op(`OP_SHR_PAIR, 30'h0000_001f, 3'h0);
		p = $signed({30'h2345_6789, 30'h0000_0005}) >>> 31;
		`CHK({sum_out, ext_out}, p)
	endtask

	task automatic t_rotate();
		ld(30'h2000_0003, 30'h2000_0003);
		op(`OP_ROL_EXT, 30'h0000_003b, 3'h0);
		`CHK(ext_out, 30'h3000_0001)
		op(`OP_ROL_SUM, 30'h3fff_ffc1, 3'h0);
		`CHK(sum_out, 30'h0000_0007)
	endtask

	// Sum is -5 and extension 10; operands straddle both bounds
	task automatic t_compare();
		word_t ys[5] = '{30'h3fff_fffa, 30'h3fff_fffb, 30'h0000_0003, 30'h0000_000a, 30'h0000_000b};
		logic signed [29:0] y;
		logic w;
		ld(30'h3fff_fffb, 30'h0000_000a);
		foreach (ys[i]) begin
			for (int l = 0; l < 8; l++) begin
				y = ys[i];
				op(`OP_COMPARE, ys[i], sel_t'(l));
				case (l)
					0: w = 1'b0;
					1: w = 1'b1;
					2: w = y <= 10;
					3: w = y > 10;
					4: w = 10 >= y && y > -5;
					5: w = y > 10 || y <= -5;
					6: w = y <= -5;
					default: w = y > -5;
				endcase
				nskip += int'(w);
				`CHK(skip, w)
				`CHK({sum_out, ext_out}, {30'h3fff_fffb, 30'h0000_000a})
			end
		end
		// The model counts the last pulse only at the edge after it
		@(posedge clk);
		#1;
		`CHK(skipped_q, 8'(nskip))
	endtask

	// An unlisted opcode must leave everything alone
	task automatic t_refuse();
		op(6'h07, 30'h0000_0001, 3'h1);
		`CHK(op_done, 1'b0)
		`CHK({sum_out, ext_out}, {30'h3fff_fffb, 30'h0000_000a})
		// Illegal opcode lets a load through; a taken compare drops it
		@(posedge clk);
		op_valid <= 1'b1;
		opcode <= 6'h07;
		load_ext <= 1'b1;
		load_data <= 30'h0000_0011;
		#1;
		`CHK(op_accept, 1'b0)
		@(posedge clk);
		opcode <= `OP_COMPARE;
		load_data <= 30'h0000_0022;
		#1;
		`CHK(op_accept, 1'b1)
		`CHK(ext_out, 30'h0000_0011)
		@(posedge clk);
		op_valid <= 1'b0;
		load_ext <= 1'b0;
		#1;
		`CHK(op_done, 1'b1)
		`CHK(skip, 1'b1)
		`CHK({sum_out, ext_out}, {30'h3fff_fffb, 30'h0000_0011})
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_shift();
		t_rotate();
		t_compare();
		t_refuse();
		conclude();
	end

	// The run needs about 120 cycles; this is ample margin
	initial begin
		#20000;
		err_count++;
		conclude();
	end
endmodule

`default_nettype wire
